// [rtl/fpec_pkg.sv]
package fpec_pkg;

  // Register file addresses of the controller
  localparam logic [11:0] ADDR_CMD_STAT  = 12'hff8;
  localparam logic [11:0] ADDR_PAGE_PROT = 12'hff9;

  // Command codes written to flash_command_reg
  localparam logic [7:0]  CMD_KEY1       = 8'h73;
  localparam logic [7:0]  CMD_KEY2       = 8'h8c;
  localparam logic [7:0]  CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0]  CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0]  CMD_SEL_PROT   = 8'h5e;

  // Address layout: 8 KB array, 512-byte pages, 1 KB sectors
  localparam int          ADDR_W         = 16;
  localparam int          FLASH_AW       = 13;
  localparam int          PAGE_LSB       = 9;
  localparam int          PAGE_MSB       = 6;
  localparam int          SECTOR_LSB     = 10;
  localparam int          SECTOR_W       = 3;

  // Reset and idle values
  localparam logic [7:0]  PAGE_RESET     = 8'h00;
  localparam logic [7:0]  PROT_RESET     = 8'h00;
  localparam logic [7:0]  RD_IDLE        = 8'h00;
  localparam logic [1:0]  STAT_RSVD      = 2'h0;

  // Six-bit status codes
  localparam logic [5:0]  ST_LOCKED      = 6'h00;
  localparam logic [5:0]  ST_KEY1        = 6'h01;
  localparam logic [5:0]  ST_KEY2        = 6'h02;
  localparam logic [5:0]  ST_UNLOCKED    = 6'h03;
  localparam logic [5:0]  ST_PROT_SEL    = 6'h04;
  localparam logic [5:0]  ST_PROG        = 6'h08;
  localparam logic [5:0]  ST_PERASE      = 6'h10;
  localparam logic [5:0]  ST_MERASE      = 6'h20;

  typedef enum logic [2:0] {
    S_LOCKED   = 3'h0,
    S_KEY1     = 3'h1,
    S_KEY2     = 3'h3,
    S_UNLOCKED = 3'h2,
    S_PROG     = 3'h6,
    S_PERASE   = 3'h7,
    S_MERASE   = 3'h5,
    S_PROT_SEL = 3'h4
  } fpec_state_t;

  typedef enum logic [1:0] {
    OP_READ   = 2'h0,
    OP_PROG   = 2'h1,
    OP_PERASE = 2'h2,
    OP_MERASE = 2'h3
  } fpec_op_t;

endpackage

// [rtl/fpec_sector_chk.sv]
`timescale 1ns/10ps
module fpec_sector_chk (
  input  wire logic [15:0] addr_i,     // Program memory byte address
  input  wire logic [7:0]  prot_i,     // Sector protection mask
  output logic             prot_o,     // Address lies in a protected sector
  output logic             in_range_o  // Address lies inside the array
);

  wire logic [fpec_pkg::SECTOR_W-1:0] sector;

  // Sector is an eighth of the array, never below one page
  assign sector     = addr_i[fpec_pkg::FLASH_AW-1:fpec_pkg::SECTOR_LSB];
  assign prot_o     = prot_i[sector];
  // Information area and unpopulated space are never programmable
  assign in_range_o =
    (addr_i[fpec_pkg::ADDR_W-1:fpec_pkg::FLASH_AW] == '0);

endmodule // fpec_sector_chk

// [rtl/fpec_array_seq.sv]
`timescale 1ns/10ps
module fpec_array_seq (
  input  wire logic             clk_i,       // System clock
  input  wire logic             rst_n_i,     // Synchronised reset, low
  input  wire logic             start_i,     // Start one operation
  input  wire fpec_pkg::fpec_op_t op_i,      // Operation to run
  input  wire logic [15:0]      addr_i,      // Byte or page address
  input  wire logic [7:0]       wdata_i,     // Byte to program
  input  wire logic [7:0]       arr_rdata_i, // Array read data
  input  wire logic             arr_done_i,  // Array step finished
  output logic                  arr_req_o,   // Array request level
  output logic [1:0]            arr_op_o,    // Array operation code
  output logic [15:0]           arr_addr_o,  // Array address
  output logic [7:0]            arr_wdata_o, // Array write data
  output logic                  done_o       // Operation finished pulse
);

  logic               req_q;
  fpec_pkg::fpec_op_t op_q;
  logic [15:0]        addr_q;
  logic [7:0]         data_q;
  logic               done_q;

  wire logic step_done = req_q && arr_done_i;
  wire logic pre_read  = step_done && (op_q == fpec_pkg::OP_READ);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      req_q  <= 1'b0;
      op_q   <= fpec_pkg::OP_READ;
      addr_q <= '0;
      data_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= step_done && !pre_read;
      if (start_i)
      begin
        req_q  <= 1'b1;
        // A program first reads the byte so that no bit can rise
        op_q   <= (op_i == fpec_pkg::OP_PROG) ? fpec_pkg::OP_READ : op_i;
        addr_q <= addr_i;
        data_q <= wdata_i;
      end
      else if (pre_read)
      begin
        op_q   <= fpec_pkg::OP_PROG;
        data_q <= data_q & arr_rdata_i;
      end
      else if (step_done)
        req_q <= 1'b0;
    end
  end

  assign arr_req_o   = req_q;
  assign arr_op_o    = op_q;
  assign arr_addr_o  = addr_q;
  assign arr_wdata_o = data_q;
  assign done_o      = done_q;

endmodule // fpec_array_seq

// [rtl/fpec_ctrl.sv]
`timescale 1ns/10ps
module fpec_ctrl (
  input  wire logic        clk_i,                  // System clock
  input  wire logic        arst_n_i,               // Async reset, low
  input  wire logic        reg_wr_i,               // Register write strobe
  input  wire logic        reg_rd_i,               // Register read strobe
  input  wire logic [11:0] reg_addr_i,             // Register file address
  input  wire logic [7:0]  reg_wdata_i,            // Register write data
  input  wire logic        reg_dbg_i,              // Access from debug_port
  output logic      [7:0]  reg_rdata_o,            // Register read data
  input  wire logic        mem_wr_i,               // Program memory store
  input  wire logic [15:0] mem_addr_i,             // Store byte address
  input  wire logic [7:0]  mem_wdata_i,            // Store byte data
  input  wire logic        mem_dbg_i,              // Store from debug_port
  input  wire logic        write_protect_option_i, // Option bit, 1 allows
  output logic             cpu_stall_o,            // Holds the CPU core
  output logic             arr_req_o,              // Array request level
  output logic      [1:0]  arr_op_o,               // Array operation code
  output logic      [15:0] arr_addr_o,             // Array address
  output logic      [7:0]  arr_wdata_o,            // Array write data
  input  wire logic [7:0]  arr_rdata_i,            // Array read data
  input  wire logic        arr_done_i              // Array step finished
);

  logic                  rst_meta_q;
  logic                  rst_n_q;
  fpec_pkg::fpec_state_t st_q;
  fpec_pkg::fpec_state_t st_d;
  logic [7:0]            page_q;
  logic [7:0]            prot_q;
  logic [7:0]            rdata_q;
  logic                  eng_start;
  fpec_pkg::fpec_op_t    eng_op;
  logic [15:0]           eng_addr;
  logic                  eng_done;

  function automatic logic [5:0] status_of(input fpec_pkg::fpec_state_t s);
    unique case (s)
      fpec_pkg::S_LOCKED:   status_of = fpec_pkg::ST_LOCKED;
      fpec_pkg::S_KEY1:     status_of = fpec_pkg::ST_KEY1;
      fpec_pkg::S_KEY2:     status_of = fpec_pkg::ST_KEY2;
      fpec_pkg::S_UNLOCKED: status_of = fpec_pkg::ST_UNLOCKED;
      fpec_pkg::S_PROT_SEL: status_of = fpec_pkg::ST_PROT_SEL;
      fpec_pkg::S_PROG:     status_of = fpec_pkg::ST_PROG;
      fpec_pkg::S_PERASE:   status_of = fpec_pkg::ST_PERASE;
      fpec_pkg::S_MERASE:   status_of = fpec_pkg::ST_MERASE;
    endcase
  endfunction

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Address decode of the shared locations
  wire logic cmd_wr   = reg_wr_i &&
                        (reg_addr_i == fpec_pkg::ADDR_CMD_STAT);
  wire logic ps_wr    = reg_wr_i && (reg_addr_i == fpec_pkg::ADDR_PAGE_PROT);
  wire logic prot_sel = (st_q == fpec_pkg::S_PROT_SEL);
  wire logic busy     = (st_q == fpec_pkg::S_PROG) ||
                        (st_q == fpec_pkg::S_PERASE) ||
                        (st_q == fpec_pkg::S_MERASE);
  wire logic [5:0] status = status_of(st_q);

  // Active page base address from the page field
  wire logic [15:0] page_addr =
    {page_q[fpec_pkg::PAGE_MSB:0], {fpec_pkg::PAGE_LSB{1'b0}}};
  wire logic page_match =
    (reg_wdata_i[fpec_pkg::PAGE_MSB:0] == page_q[fpec_pkg::PAGE_MSB:0]);
  wire logic in_page =
    (mem_addr_i[fpec_pkg::ADDR_W-1:fpec_pkg::PAGE_LSB] ==
     page_q[fpec_pkg::PAGE_MSB:0]);

  wire logic pg_prot;
  wire logic pg_in_range;
  wire logic mem_prot;
  wire logic mem_in_range;

  fpec_sector_chk u_page_chk (
    .addr_i     (page_addr),
    .prot_i     (prot_q),
    .prot_o     (pg_prot),
    .in_range_o (pg_in_range)
  );

  fpec_sector_chk u_store_chk (
    .addr_i     (mem_addr_i),
    .prot_i     (prot_q),
    .prot_o     (mem_prot),
    .in_range_o (mem_in_range)
  );

  // Debug access ignores the option bit and the protection mask
  wire logic user_ok  = write_protect_option_i;
  wire logic erase_ok = pg_in_range &&
                        (reg_dbg_i || (user_ok && !pg_prot));
  wire logic mass_ok  = reg_dbg_i;
  wire logic prog_ok  = mem_in_range &&
                        (mem_dbg_i || (user_ok && !mem_prot && in_page));
  // Outside the three busy states, any command that is not a key, an erase or the protection select falls back to locked
  wire fpec_pkg::fpec_state_t other_cmd =
    (reg_wdata_i == fpec_pkg::CMD_SEL_PROT) ? fpec_pkg::S_PROT_SEL
                                            : fpec_pkg::S_LOCKED;

  always_comb
  begin
    st_d      = st_q;
    eng_start = 1'b0;
    eng_op    = fpec_pkg::OP_PROG;
    eng_addr  = mem_addr_i;
    unique case (st_q)
      fpec_pkg::S_LOCKED:
      begin
        if (cmd_wr)
          st_d = (reg_wdata_i == fpec_pkg::CMD_KEY1) ? fpec_pkg::S_KEY1
                                                      : other_cmd;
      end
      fpec_pkg::S_KEY1:
      begin
        if (cmd_wr)
          st_d = (reg_wdata_i == fpec_pkg::CMD_KEY2) ? fpec_pkg::S_KEY2
                                                      : other_cmd;
        else if (ps_wr)
          st_d = fpec_pkg::S_LOCKED;
      end
      fpec_pkg::S_KEY2:
      begin
        if (cmd_wr)
          st_d = other_cmd;
        else if (ps_wr)
          st_d = page_match ? fpec_pkg::S_UNLOCKED
                            : fpec_pkg::S_LOCKED;
      end
      fpec_pkg::S_UNLOCKED:
      begin
        if (cmd_wr)
        begin
          if (reg_wdata_i == fpec_pkg::CMD_PAGE_ERASE)
          begin
            st_d      = erase_ok ? fpec_pkg::S_PERASE
                                 : fpec_pkg::S_LOCKED;
            eng_start = erase_ok;
            eng_op    = fpec_pkg::OP_PERASE;
            eng_addr  = page_addr;
          end
          else if (reg_wdata_i == fpec_pkg::CMD_MASS_ERASE)
          begin
            st_d      = mass_ok ? fpec_pkg::S_MERASE
                                : fpec_pkg::S_LOCKED;
            eng_start = mass_ok;
            eng_op    = fpec_pkg::OP_MERASE;
            eng_addr  = page_addr;
          end
          else
            st_d = other_cmd;
        end
        else if (mem_wr_i)
        begin
          st_d      = prog_ok ? fpec_pkg::S_PROG
                              : fpec_pkg::S_LOCKED;
          eng_start = prog_ok;
        end
      end
      fpec_pkg::S_PROT_SEL:
      begin
        if (cmd_wr)
          st_d = other_cmd;
      end
      fpec_pkg::S_PROG:
      begin
        if (eng_done)
          st_d = fpec_pkg::S_UNLOCKED;
      end
      fpec_pkg::S_PERASE:
      begin
        if (eng_done)
          st_d = fpec_pkg::S_LOCKED;
      end
      fpec_pkg::S_MERASE:
      begin
        if (eng_done)
          st_d = fpec_pkg::S_LOCKED;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      st_q <= fpec_pkg::S_LOCKED;
    else
      st_q <= st_d;
  end

  // Page select is open while locked; debug may also move an open page
  wire logic page_load = ps_wr && !prot_sel &&
    ((st_q == fpec_pkg::S_LOCKED) ||
     ((st_q == fpec_pkg::S_UNLOCKED) && reg_dbg_i));

  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      page_q <= fpec_pkg::PAGE_RESET;
    else if (page_load)
      page_q <= reg_wdata_i;
  end

  // Set-only mask: no write path can clear a bit, so one glitchy
  // store cannot drop protection before the next reset
  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      prot_q <= fpec_pkg::PROT_RESET;
    else if (ps_wr && prot_sel)
      prot_q <= prot_q | reg_wdata_i;
  end

  wire logic [7:0] rd_mux =
    (reg_addr_i == fpec_pkg::ADDR_CMD_STAT)  ? {fpec_pkg::STAT_RSVD, status} :
    (reg_addr_i == fpec_pkg::ADDR_PAGE_PROT) ? (prot_sel ? prot_q : page_q) :
                                               fpec_pkg::RD_IDLE;

  always_ff @(posedge clk_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
      rdata_q <= fpec_pkg::RD_IDLE;
    else if (reg_rd_i)
      rdata_q <= rd_mux;
  end

  fpec_array_seq u_seq (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_q),
    .start_i     (eng_start),
    .op_i        (eng_op),
    .addr_i      (eng_addr),
    .wdata_i     (mem_wdata_i),
    .arr_rdata_i (arr_rdata_i),
    .arr_done_i  (arr_done_i),
    .arr_req_o   (arr_req_o),
    .arr_op_o    (arr_op_o),
    .arr_addr_o  (arr_addr_o),
    .arr_wdata_o (arr_wdata_o),
    .done_o      (eng_done)
  );

  // System clock keeps running; only the core is held
  assign cpu_stall_o = busy;
  assign reg_rdata_o = rdata_q;

  reset_locked_a: assert property (
    @(posedge clk_i) $rose(rst_n_q)
    |-> (st_q == fpec_pkg::S_LOCKED) && !arr_req_o)
    else $error("controller not locked after reset");

  page_compare_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    (st_q == fpec_pkg::S_KEY2) && ps_wr && !cmd_wr && !page_match
    |=> (st_q == fpec_pkg::S_LOCKED))
    else $error("mismatched page write did not relock");

  erase_start_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    (st_q == fpec_pkg::S_UNLOCKED) && cmd_wr &&
    (reg_wdata_i == fpec_pkg::CMD_PAGE_ERASE) && erase_ok
    |=> (st_q == fpec_pkg::S_PERASE) && arr_req_o &&
        (arr_addr_o == $past(page_addr)))
    else $error("page erase did not start on the active page");

  bad_cmd_lock_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    (st_q == fpec_pkg::S_UNLOCKED) && cmd_wr &&
    (reg_wdata_i != fpec_pkg::CMD_PAGE_ERASE) &&
    (reg_wdata_i != fpec_pkg::CMD_MASS_ERASE) &&
    (reg_wdata_i != fpec_pkg::CMD_SEL_PROT)
    |=> (st_q == fpec_pkg::S_LOCKED) && !arr_req_o)
    else $error("unknown command left controller unlocked");

  user_mass_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    (st_q == fpec_pkg::S_UNLOCKED) && cmd_wr && !reg_dbg_i &&
    (reg_wdata_i == fpec_pkg::CMD_MASS_ERASE)
    |=> (st_q == fpec_pkg::S_LOCKED) && !arr_req_o)
    else $error("user mass erase was accepted");

  option_block_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    (st_q == fpec_pkg::S_UNLOCKED) && !cmd_wr && mem_wr_i &&
    !mem_dbg_i && !write_protect_option_i
    |=> (st_q == fpec_pkg::S_LOCKED) && !arr_req_o)
    else $error("user store passed a cleared write-protect option");

  prot_sticky_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    ((prot_q & $past(prot_q)) == $past(prot_q)))
    else $error("protection bit was cleared");

  stall_busy_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    arr_req_o |-> cpu_stall_o)
    else $error("array busy without stalling the core");

  erase_relock_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    (st_q == fpec_pkg::S_PERASE) && eng_done
    |=> (st_q == fpec_pkg::S_LOCKED) && !cpu_stall_o)
    else $error("page erase did not relock");

  unlock_status_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_q)
    (st_q == fpec_pkg::S_UNLOCKED) && reg_rd_i &&
    (reg_addr_i == fpec_pkg::ADDR_CMD_STAT)
    |=> (reg_rdata_o == {fpec_pkg::STAT_RSVD, fpec_pkg::ST_UNLOCKED}))
    else $error("unlocked status code wrong");

endmodule // fpec_ctrl

// [sim/fpec_array_model.sv]
`timescale 1ns/10ps
module fpec_array_model (
  input  wire logic        clk_i,       // System clock
  input  wire logic [3:0]  dly_i,       // Extra cycles before each done
  input  wire logic        arr_req_i,   // Array request level
  input  wire logic [1:0]  arr_op_i,    // Array operation code
  input  wire logic [15:0] arr_addr_i,  // Array address
  input  wire logic [7:0]  arr_wdata_i, // Array write data
  output logic      [7:0]  arr_rdata_o, // Array read data
  output logic             arr_done_o   // Step finished pulse
);
  logic [7:0] mem [8192];
  logic [3:0] wait_q = 4'h0;
  logic       gap_q  = 1'b0;

  initial
  begin
    arr_done_o  = 1'b0;
    arr_rdata_o = 8'h00;
    for (int i = 0; i < 8192; i++) mem[i] = 8'hff;
  end

  // A gap cycle after each done lets the controller change op first
  always @(posedge clk_i)
  begin
    arr_done_o  <= 1'b0;
    // Read data toggles outside done so stale values never match
    arr_rdata_o <= ~arr_rdata_o;
    if (gap_q)
      gap_q <= 1'b0;
    else if (arr_req_i && wait_q != dly_i)
      wait_q <= wait_q + 4'h1;
    else if (arr_req_i)
    begin
      wait_q     <= 4'h0;
      gap_q      <= 1'b1;
      arr_done_o <= 1'b1;
      case (arr_op_i)
        2'h0: arr_rdata_o <= mem[arr_addr_i[12:0]];
        2'h1: mem[arr_addr_i[12:0]] <= mem[arr_addr_i[12:0]]
                                       & arr_wdata_i;
        2'h2: for (int i = 0; i < 512; i++)
                mem[{arr_addr_i[12:9], 9'(i)}] <= 8'hff;
        default: for (int i = 0; i < 8192; i++) mem[i] <= 8'hff;
      endcase
    end
  end
endmodule // fpec_array_model

// [sim/flash_program_erase_protect_ctrl_bench.sv]
`timescale 1ns/10ps
module flash_program_erase_protect_ctrl_bench;
  logic clk_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, reg_dbg_i = 0;
  logic mem_wr_i = 0, mem_dbg_i = 0, wp = 1;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0]  reg_wdata_i = 8'h00, mem_wdata_i = 8'h00, pg = 0, pm = 0;
  logic [15:0] mem_addr_i = 16'h0000;
  logic [3:0]  dly = 4'h0;
  logic [7:0]  reg_rdata_o, arr_wdata_o, arr_rdata_i, img [8192];
  logic [15:0] arr_addr_o;
  logic [1:0]  arr_op_o;
  logic        cpu_stall_o, arr_req_o, arr_done_i;
  int          failures = 0, checks_done = 0, cyc = 0, st = 0;
  localparam logic [11:0] CS = fpec_pkg::ADDR_CMD_STAT;
  localparam logic [11:0] PP = fpec_pkg::ADDR_PAGE_PROT;

  fpec_ctrl u_fpec_ctrl (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_dbg_i(reg_dbg_i),
    .reg_rdata_o(reg_rdata_o), .mem_wr_i(mem_wr_i), .mem_addr_i(mem_addr_i),
    .mem_wdata_i(mem_wdata_i), .mem_dbg_i(mem_dbg_i),
    .write_protect_option_i(wp), .cpu_stall_o(cpu_stall_o),
    .arr_req_o(arr_req_o), .arr_op_o(arr_op_o), .arr_addr_o(arr_addr_o),
    .arr_wdata_o(arr_wdata_o), .arr_rdata_i(arr_rdata_i),
    .arr_done_i(arr_done_i));
  fpec_array_model u_fpec_array_model (.clk_i(clk_i), .dly_i(dly),
    .arr_req_i(arr_req_o), .arr_op_i(arr_op_o), .arr_addr_i(arr_addr_o),
    .arr_wdata_i(arr_wdata_o), .arr_rdata_o(arr_rdata_i),
    .arr_done_o(arr_done_i));

  always #2 clk_i = ~clk_i;

  task close_out;
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Run is far shorter than this; hitting it means a hang
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      failures++;
      close_out;
    end
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task erase(input int base, input int n);
    for (int i = 0; i < n; i++) img[base+i] = 8'hff;
  endtask

  task settle(input logic busy, input int code);
    int n;
    int keep;
    chk(8'(cpu_stall_o), 8'(busy));
    // A running operation is polled with a non-debug status read
    if (busy)
    begin
      keep = st;
      st = code;
      rd(CS);
      st = keep;
    end
    for (n = 0; n < 200 && cpu_stall_o !== 1'b0; n++) @(negedge clk_i);
    chk(8'(cpu_stall_o), 8'h00);
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d, input logic dbg);
    logic busy;
    int   code;
    busy = 0;
    code = 0;
    @(negedge clk_i);
    dly = 4'($urandom_range(0, 6));
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_dbg_i = dbg;
    reg_wr_i = 1;
    @(negedge clk_i);
    reg_wr_i = 0;
    if (a == CS)
    begin
      if (d == fpec_pkg::CMD_SEL_PROT) st = 4;
      else if (st == 0 && d == fpec_pkg::CMD_KEY1) st = 1;
      else if (st == 1 && d == fpec_pkg::CMD_KEY2) st = 2;
      else
      begin
        if (st == 3 && d == fpec_pkg::CMD_PAGE_ERASE && pg[6:4] == 0
            && (dbg || (wp && !pm[pg[3:1]])))
        begin
          busy = 1;
          code = fpec_pkg::ST_PERASE;
          erase(int'(pg[3:0]) * 512, 512);
        end
        if (st == 3 && d == fpec_pkg::CMD_MASS_ERASE && dbg)
        begin
          busy = 1;
          code = fpec_pkg::ST_MERASE;
          erase(0, 8192);
        end
        st = 0;
      end
    end
    else if (a == PP)
    begin
      if (st == 4) pm = pm | d;
      else if (st == 0 || (st == 3 && dbg)) pg = d;
      else if (st == 2 && d == pg) st = 3;
      // A user page write to an open page is ignored
      else if (st != 3) st = 0;
    end
    settle(busy, code);
  endtask

  task rd(input logic [11:0] a);
    logic [7:0] e;
    e = (a == CS) ? 8'(st) : (a == PP) ? ((st == 4) ? pm : pg)
        : fpec_pkg::RD_IDLE;
    @(negedge clk_i);
    reg_addr_i = a;
    reg_dbg_i = 0;
    reg_rd_i = 1;
    @(negedge clk_i);
    reg_rd_i = 0;
    chk(reg_rdata_o, e);
  endtask

  task store(input logic [15:0] a, input logic [7:0] d, input logic dbg);
    logic ok;
    ok = st == 3 && a < 16'h2000
         && (dbg || (a[15:9] == pg[6:0] && wp && !pm[a[12:10]]));
    @(negedge clk_i);
    dly = 4'($urandom_range(0, 6));
    mem_addr_i = a;
    mem_wdata_i = d;
    mem_dbg_i = dbg;
    mem_wr_i = 1;
    @(negedge clk_i);
    mem_wr_i = 0;
    if (ok) img[a[12:0]] = img[a[12:0]] & d;
    else if (st == 3) st = 0;
    settle(ok, fpec_pkg::ST_PROG);
  endtask

  task unlock(input logic [7:0] p, input logic dbg);
    wr(PP, p, dbg);
    wr(CS, fpec_pkg::CMD_KEY1, dbg);
    wr(CS, fpec_pkg::CMD_KEY2, dbg);
    wr(PP, p, dbg);
  endtask

  task done_test(input string nm);
    for (int i = 0; i < 8192; i++)
      chk(u_fpec_array_model.mem[i], img[i]);
    $display("test %s done", nm);
  endtask

  initial
  begin
    void'($urandom(32'h478c972a));
    for (int i = 0; i < 8192; i++) img[i] = 8'hff;
    repeat (6) @(negedge clk_i);
    arst_n_i = 1;
    repeat (3) @(negedge clk_i);
    rd(CS);
    rd(PP);
    rd(12'h100);
    store(16'h0400, 8'h00, 0);
    done_test("reset");
    unlock(8'h02, 0);
    rd(CS);
    repeat (6) store(16'(16'h0400 + $urandom_range(0, 511)), 8'($urandom), 0);
    store(16'h0410, 8'hf0, 0);
    store(16'h0410, 8'h3c, 0);
    store(16'h0600, 8'h00, 0);
    rd(CS);
    done_test("program");
    wr(PP, 8'h03, 0);
    wr(CS, fpec_pkg::CMD_KEY1, 0);
    wr(CS, fpec_pkg::CMD_KEY2, 0);
    wr(PP, 8'h04, 0);
    rd(CS);
    unlock(8'h02, 0);
    wr(CS, fpec_pkg::CMD_PAGE_ERASE, 0);
    rd(CS);
    done_test("page erase");
    unlock(8'h05, 0);
    wr(CS, 8'h11, 0);
    rd(CS);
    unlock(8'h05, 0);
    store(16'h0a21, 8'($urandom), 0);
    wr(CS, 8'h00, 0);
    rd(CS);
    done_test("relock");
    unlock(8'h06, 0);
    wr(CS, fpec_pkg::CMD_MASS_ERASE, 0);
    rd(CS);
    unlock(8'h06, 1);
    wr(CS, fpec_pkg::CMD_MASS_ERASE, 1);
    rd(CS);
    done_test("mass erase");
    wr(CS, 8'h00, 0);
    wr(CS, fpec_pkg::CMD_SEL_PROT, 0);
    rd(CS);
    wr(PP, 8'h02, 0);
    rd(PP);
    wr(PP, 8'h00, 0);
    rd(PP);
    wr(CS, 8'h00, 0);
    rd(CS);
    rd(PP);
    unlock(8'h02, 0);
    store(16'h0400, 8'h00, 0);
    unlock(8'h02, 1);
    store(16'h0455, 8'h12, 1);
    wr(CS, 8'h00, 0);
    unlock(8'h02, 0);
    wr(CS, fpec_pkg::CMD_PAGE_ERASE, 0);
    rd(CS);
    unlock(8'h04, 0);
    store(16'h0833, 8'h5a, 0);
    wr(CS, 8'h00, 0);
    unlock(8'h03, 1);
    store(16'h0600, 8'h00, 1);
    wr(CS, fpec_pkg::CMD_PAGE_ERASE, 1);
    done_test("protection");
    wp = 0;
    unlock(8'h04, 0);
    store(16'h0801, 8'h00, 0);
    unlock(8'h04, 0);
    wr(CS, fpec_pkg::CMD_PAGE_ERASE, 0);
    rd(CS);
    wp = 1;
    done_test("option bit");
    arst_n_i = 0;
    repeat (2) @(negedge clk_i);
    arst_n_i = 1;
    repeat (3) @(negedge clk_i);
    st = 0;
    pg = 0;
    pm = 0;
    wr(CS, fpec_pkg::CMD_SEL_PROT, 0);
    rd(PP);
    wr(CS, 8'h00, 0);
    done_test("second reset");
    close_out;
  end
endmodule // flash_program_erase_protect_ctrl_bench
